// *** verilog/sles_lane_status.sv ***
// Purpose: lane 5 / lane 6 receive status registers with threshold error flags
// Assumes: error counters, threshold and sync levels are produced elsewhere, same clock
// Notes:   plain register port, byte addresses, 8-bit data, read data one cycle later
`timescale 1ns/1ps
`include "sles_map.svh"

module sles_lane_status (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_sys_rst,
    input  wire logic                 i_clk_en,
    input  wire sles_pkg::sles_addr_t i_addr,
    input  wire sles_pkg::sles_byte_t i_wr_data,
    input  wire logic                 i_wr_stb,
    input  wire logic                 i_rd_stb,
    input  wire sles_pkg::sles_cnt_t  i_disp_err_cnt,
    input  wire sles_pkg::sles_cnt_t  i_invalid_err_cnt,
    input  wire sles_pkg::sles_cnt_t  i_ctrl_err_cnt,
    input  wire sles_pkg::sles_cnt_t  i_error_threshold,
    input  wire logic                 i_lane6_deskew_ok,
    input  wire logic                 i_lane6_init_sync,
    input  wire logic                 i_lane5_group_sync,
    output logic                      o_rd_valid,
    output sles_pkg::sles_byte_t      o_rd_data,
    output logic                      o_skip_initial_alignment,
    output logic                      o_irq
);
    sles_flag_if flags ();

    sles_pkg::sles_byte_t ctrl_q;
    sles_pkg::sles_byte_t irq_status_q;
    sles_pkg::sles_byte_t irq_status_d;
    sles_pkg::sles_byte_t irq_mask_q;
    sles_pkg::sles_byte_t lane5_status;
    sles_pkg::sles_byte_t rd_mux;
    sles_pkg::sles_byte_t rd_data_q;
    sles_pkg::sles_byte_t clr_bits;
    logic                 rd_valid_q;
    logic                 irq_q;
    logic                 wr_ctrl;
    logic                 wr_irq_status;
    logic                 wr_irq_mask;
    logic                 skip_align;

    // named so each sticky bit takes its own reset bit rather than a shifted byte
    localparam sles_pkg::sles_byte_t irq_status_rst = `SLES_IRQ_STATUS_RST;

    assign skip_align = ctrl_q[`SLES_CTRL_SKIP_BIT];

    sles_flag_gen u_flag_gen (
        .i_clk_sys          (i_clk_sys),
        .i_sys_rst          (i_sys_rst),
        .i_clk_en           (i_clk_en),
        .i_disp_err_cnt     (i_disp_err_cnt),
        .i_invalid_err_cnt  (i_invalid_err_cnt),
        .i_ctrl_err_cnt     (i_ctrl_err_cnt),
        .i_error_threshold  (i_error_threshold),
        .i_lane6_deskew_ok  (i_lane6_deskew_ok),
        .i_lane6_init_sync  (i_lane6_init_sync),
        .i_lane5_group_sync (i_lane5_group_sync),
        .flags              (flags.gen)
    );

    sles_evt_det u_evt_det (
        .i_clk_sys                (i_clk_sys),
        .i_sys_rst                (i_sys_rst),
        .i_clk_en                 (i_clk_en),
        .i_skip_initial_alignment (skip_align),
        .flags                    (flags.det)
    );

    // write decode
    always_comb begin
        wr_ctrl       = 1'b0;
        wr_irq_status = 1'b0;
        wr_irq_mask   = 1'b0;
        if (i_wr_stb && i_addr == `SLES_CTRL_ADDR) begin
            wr_ctrl = 1'b1;
        end else if (i_wr_stb && i_addr == `SLES_IRQ_STATUS_ADDR) begin
            wr_irq_status = 1'b1;
        end else if (i_wr_stb && i_addr == `SLES_IRQ_MASK_ADDR) begin
            wr_irq_mask = 1'b1;
        end
    end

    // control register: holds the skip-alignment setting
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ctrl_q <= `SLES_CTRL_RST;
        end else if (i_clk_en && wr_ctrl) begin
            ctrl_q <= i_wr_data & `SLES_CTRL_USED;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            irq_mask_q <= `SLES_IRQ_MASK_RST;
        end else if (i_clk_en && wr_irq_mask) begin
            irq_mask_q <= i_wr_data & `SLES_EVT_USED;
        end
    end

    assign clr_bits = wr_irq_status ? i_wr_data : 8'h00;

    // sticky status, one per bit; an event in the clearing cycle survives the clear
    genvar b;
    generate
        for (b = 0; b < `SLES_DATA_W; b++) begin : g_sticky
            always_comb begin
                irq_status_d[b] = (irq_status_q[b] & ~clr_bits[b]) | flags.events[b];
            end
            always_ff @(posedge i_clk_sys) begin
                if (i_sys_rst) begin
                    irq_status_q[b] <= irq_status_rst[b];
                end else if (i_clk_en) begin
                    irq_status_q[b] <= irq_status_d[b];
                end
            end
        end
    endgenerate

    // registered so the pin is glitch-free; it trails the status bit by one cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            irq_q <= 1'b0;
        end else if (i_clk_en) begin
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    always_comb begin
        lane5_status                 = `SLES_STATUS_RST;
        lane5_status[`SLES_BIT_LANE5_GROUP_SYNC_FLAG] = flags.lane5_sync;
    end

    // read decode; reads are side-effect free, unmapped addresses return zero
    always_comb begin
        rd_mux = 8'h00;
        if (i_addr == `SLES_LANE6_STATUS_ADDR) begin
            rd_mux = flags.lane6_status;
        end else if (i_addr == `SLES_LANE5_STATUS_ADDR) begin
            rd_mux = lane5_status;
        end else if (i_addr == `SLES_IRQ_STATUS_ADDR) begin
            rd_mux = irq_status_q;
        end else if (i_addr == `SLES_IRQ_MASK_ADDR) begin
            rd_mux = irq_mask_q;
        end else if (i_addr == `SLES_CTRL_ADDR) begin
            rd_mux = ctrl_q;
        end
    end

    // data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else if (i_clk_en) begin
            rd_data_q  <= i_rd_stb ? rd_mux : 8'h00;
            rd_valid_q <= i_rd_stb;
        end
    end

    assign o_rd_data                = rd_data_q;
    assign o_rd_valid               = rd_valid_q;
    assign o_irq                    = irq_q;
    assign o_skip_initial_alignment = ctrl_q[`SLES_CTRL_SKIP_BIT];
endmodule

// *** verilog/sles_map.svh ***
// Purpose: address map, field positions and reset values of the lane status block
// Assumes: byte addresses on a 12-bit plain register port, 8-bit data
// Notes:   definitions only
`ifndef SLES_MAP_SVH
`define SLES_MAP_SVH

`define SLES_ADDR_W             12
`define SLES_DATA_W             8
`define SLES_CNT_W              8

`define SLES_LANE5_STATUS_ADDR  12'h4b5
`define SLES_LANE6_STATUS_ADDR  12'h4b6
`define SLES_IRQ_STATUS_ADDR    12'h4c0
`define SLES_IRQ_MASK_ADDR      12'h4c1
`define SLES_CTRL_ADDR          12'h4c2

`define SLES_BIT_DISP           7
`define SLES_BIT_NIT            6
`define SLES_BIT_UEK            5
`define SLES_BIT_DESKEW         4
`define SLES_BIT_ILS            3
`define SLES_BIT_LANE5_GROUP_SYNC_FLAG           0
`define SLES_CTRL_SKIP_BIT      0

`define SLES_STATUS_RST         8'h00
`define SLES_IRQ_STATUS_RST     8'h00
`define SLES_IRQ_MASK_RST       8'h00
`define SLES_CTRL_RST           8'h00
`define SLES_EVT_USED           8'hf9
`define SLES_CTRL_USED          8'h01

`endif

// *** verilog/sles_pkg.sv ***
// Purpose: shared types of the lane status block
// Assumes: constants live in sles_map.svh
// Notes:   types only
`include "sles_map.svh"

package sles_pkg;
    typedef logic [`SLES_ADDR_W-1:0] sles_addr_t;
    typedef logic [`SLES_DATA_W-1:0] sles_byte_t;
    typedef logic [`SLES_CNT_W-1:0]  sles_cnt_t;

    // the three error kinds compared against the threshold
    typedef enum logic [1:0] {
        SLES_ERR_DISP = 2'h0,
        SLES_ERR_NIT  = 2'h1,
        SLES_ERR_UEK  = 2'h2
    } sles_err_kind_t;
endpackage

// *** verilog/sles_flag_if.sv ***
// Purpose: carries lane flags and status events between the block's modules
// Assumes: one clock domain
// Notes:   gen drives flags, det drives events, core reads both
`timescale 1ns/1ps

interface sles_flag_if;
    sles_pkg::sles_byte_t lane6_status;
    logic                 lane5_sync;
    sles_pkg::sles_byte_t events;

    modport gen  (output lane6_status, output lane5_sync);
    modport det  (input lane6_status, input lane5_sync, output events);
    modport core (input lane6_status, input lane5_sync, input events);
endinterface

// *** verilog/sles_flag_gen.sv ***
// Purpose: threshold compare of the lane 6 error counts and capture of sync levels
// Assumes: counts and threshold are synchronous to i_clk_sys
// Notes:   flags are recomputed every enabled cycle, nothing here is read-sensitive
`timescale 1ns/1ps
`include "sles_map.svh"

module sles_flag_gen (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_sys_rst,
    input  wire logic                 i_clk_en,
    input  wire sles_pkg::sles_cnt_t  i_disp_err_cnt,
    input  wire sles_pkg::sles_cnt_t  i_invalid_err_cnt,
    input  wire sles_pkg::sles_cnt_t  i_ctrl_err_cnt,
    input  wire sles_pkg::sles_cnt_t  i_error_threshold,
    input  wire logic                 i_lane6_deskew_ok,
    input  wire logic                 i_lane6_init_sync,
    input  wire logic                 i_lane5_group_sync,
    sles_flag_if.gen                  flags
);
    sles_pkg::sles_cnt_t cnt [3];
    logic [2:0]          err_flag_q;
    logic                deskew_q;
    logic                init_sync_q;
    logic                group_sync_q;

    assign cnt[sles_pkg::SLES_ERR_DISP] = i_disp_err_cnt;
    assign cnt[sles_pkg::SLES_ERR_NIT]  = i_invalid_err_cnt;
    assign cnt[sles_pkg::SLES_ERR_UEK]  = i_ctrl_err_cnt;

    // at-or-above: a count equal to the threshold already raises the flag
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_cmp
            always_ff @(posedge i_clk_sys) begin
                if (i_sys_rst) begin
                    err_flag_q[g] <= 1'b0;
                end else if (i_clk_en) begin
                    err_flag_q[g] <= (cnt[g] >= i_error_threshold);
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            deskew_q     <= 1'b0;
            init_sync_q  <= 1'b0;
            group_sync_q <= 1'b0;
        end else if (i_clk_en) begin
            deskew_q     <= i_lane6_deskew_ok;
            init_sync_q  <= i_lane6_init_sync;
            group_sync_q <= i_lane5_group_sync;
        end
    end

    always_comb begin
        flags.lane6_status                   = `SLES_STATUS_RST;
        flags.lane6_status[`SLES_BIT_DISP]   = err_flag_q[sles_pkg::SLES_ERR_DISP];
        flags.lane6_status[`SLES_BIT_NIT]    = err_flag_q[sles_pkg::SLES_ERR_NIT];
        flags.lane6_status[`SLES_BIT_UEK]    = err_flag_q[sles_pkg::SLES_ERR_UEK];
        flags.lane6_status[`SLES_BIT_DESKEW] = deskew_q;
        flags.lane6_status[`SLES_BIT_ILS]    = init_sync_q;
    end

    assign flags.lane5_sync = group_sync_q;
endmodule

// *** verilog/sles_evt_det.sv ***
// Purpose: turns flag transitions into one-cycle status events
// Assumes: flags come from sles_flag_gen, same clock
// Notes:   event layout matches the lane 6 status layout, bit 0 is lane 5 sync
`timescale 1ns/1ps
`include "sles_map.svh"

module sles_evt_det (
    input  wire logic  i_clk_sys,
    input  wire logic  i_sys_rst,
    input  wire logic  i_clk_en,
    input  wire logic  i_skip_initial_alignment,
    sles_flag_if.det   flags
);
    sles_pkg::sles_byte_t cur;
    sles_pkg::sles_byte_t prev_q;
    sles_pkg::sles_byte_t rise;
    sles_pkg::sles_byte_t fall;

    always_comb begin
        cur                 = flags.lane6_status;
        cur[`SLES_BIT_LANE5_GROUP_SYNC_FLAG] = flags.lane5_sync;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            prev_q <= `SLES_STATUS_RST;
        end else if (i_clk_en) begin
            prev_q <= cur;
        end
    end

    assign rise = cur & ~prev_q;
    assign fall = ~cur & prev_q;

    // alignment indications mean nothing when the alignment sequence is skipped,
    // so their loss must not raise an event then
    always_comb begin
        flags.events                   = 8'h00;
        flags.events[`SLES_BIT_DISP]   = rise[`SLES_BIT_DISP];
        flags.events[`SLES_BIT_NIT]    = rise[`SLES_BIT_NIT];
        flags.events[`SLES_BIT_UEK]    = rise[`SLES_BIT_UEK];
        flags.events[`SLES_BIT_DESKEW] = fall[`SLES_BIT_DESKEW] & ~i_skip_initial_alignment;
        flags.events[`SLES_BIT_ILS]    = fall[`SLES_BIT_ILS] & ~i_skip_initial_alignment;
        flags.events[`SLES_BIT_LANE5_GROUP_SYNC_FLAG]   = fall[`SLES_BIT_LANE5_GROUP_SYNC_FLAG];
        if (!i_clk_en) begin
            flags.events = 8'h00;
        end
    end
endmodule

// *** verification/sles_lane_status_monitor.sv ***
// Purpose: checks read-back of the lane flags against the live lane inputs
// Assumes: clock enable held high by the bench whenever a read is in flight
// Notes:   read data show inputs sampled two edges before they appear
`timescale 1ns/1ps
`include "sles_map.svh"

module sles_lane_status_monitor (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_sys_rst,
    input  wire sles_pkg::sles_addr_t i_addr,
    input  wire logic                 i_rd_stb,
    input  wire sles_pkg::sles_cnt_t  i_disp_err_cnt,
    input  wire sles_pkg::sles_cnt_t  i_invalid_err_cnt,
    input  wire sles_pkg::sles_cnt_t  i_ctrl_err_cnt,
    input  wire sles_pkg::sles_cnt_t  i_error_threshold,
    input  wire logic                 i_lane6_deskew_ok,
    input  wire logic                 i_lane6_init_sync,
    input  wire logic                 i_lane5_group_sync,
    input  wire logic                 o_rd_valid,
    input  wire sles_pkg::sles_byte_t o_rd_data
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    // a read whose flags were computed from inputs seen after reset
    sequence s_rd6;
        o_rd_valid && $past(i_addr) == `SLES_LANE6_STATUS_ADDR && !$past(i_sys_rst, 2);
    endsequence

    property p_disp_flag;
        s_rd6 |-> o_rd_data[7] == ($past(i_disp_err_cnt, 2) >= $past(i_error_threshold, 2));
    endproperty
    a_disp_flag: assert property (p_disp_flag) else $error("disparity flag wrong");
    property p_nit_flag;
        s_rd6 |-> o_rd_data[6] == ($past(i_invalid_err_cnt, 2) >= $past(i_error_threshold, 2));
    endproperty
    a_nit_flag: assert property (p_nit_flag) else $error("invalid symbol flag wrong");
    property p_uek_flag;
        s_rd6 |-> o_rd_data[5] == ($past(i_ctrl_err_cnt, 2) >= $past(i_error_threshold, 2));
    endproperty
    a_uek_flag: assert property (p_uek_flag) else $error("control char flag wrong");
    property p_deskew;
        s_rd6 |-> o_rd_data[4] == $past(i_lane6_deskew_ok, 2);
    endproperty
    a_deskew: assert property (p_deskew) else $error("deskew bit wrong");
    property p_init_sync;
        s_rd6 |-> o_rd_data[3:1] == {$past(i_lane6_init_sync, 2), 2'h0};
    endproperty
    a_init_sync: assert property (p_init_sync) else $error("initial sync bit wrong");
    property p_lane5;
        o_rd_valid && $past(i_addr) == `SLES_LANE5_STATUS_ADDR && !$past(i_sys_rst, 2)
            |-> o_rd_data == {7'h00, $past(i_lane5_group_sync, 2)};
    endproperty
    a_lane5: assert property (p_lane5) else $error("lane 5 sync bit wrong");
    property p_rd_pulse;
        !$past(i_sys_rst) |-> o_rd_valid == $past(i_rd_stb);
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read valid timing wrong");
    property p_rd_quiet;
        !o_rd_valid |-> o_rd_data == 8'h00;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data not idle");
endmodule

// *** verification/sles_lane_src.sv ***
// Purpose: far-end lane source model, drives error counts and sync levels
// Assumes: a count or level changes only when the bench loads it
// Notes:   values hold between loads, as a settled receive path would
`timescale 1ns/1ps

module sles_lane_src (
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_sys_rst,
    input  wire logic                     i_load,
    input  wire sles_pkg::sles_err_kind_t i_kind,
    input  wire sles_pkg::sles_cnt_t      i_value,
    input  wire logic [2:0]               i_sync,
    output sles_pkg::sles_cnt_t           o_cnt [3],
    output logic [2:0]                    o_sync
);
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_cnt  <= '{default: 8'h00};
            o_sync <= 3'h0;
        end else if (i_load) begin
            o_cnt[i_kind] <= i_value;
            o_sync        <= i_sync;
        end
    end
endmodule

// *** verification/sles_lane_status_tb.sv ***
// Purpose: self-checking bench for the lane status block
// Assumes: clock enable high except for the final masked-write test, far end modelled by sles_lane_src
// Notes:   expected read data queue up at the strobe, checked when valid shows
`timescale 1ns/1ps
`include "sles_map.svh"

module sles_lane_status_tb;
    localparam sles_pkg::sles_addr_t A5 = `SLES_LANE5_STATUS_ADDR;
    localparam sles_pkg::sles_addr_t A6 = `SLES_LANE6_STATUS_ADDR;
    localparam sles_pkg::sles_addr_t AS = `SLES_IRQ_STATUS_ADDR;
    localparam sles_pkg::sles_addr_t AM = `SLES_IRQ_MASK_ADDR;
    localparam sles_pkg::sles_addr_t AC = `SLES_CTRL_ADDR;
    logic                     i_clk_sys = 1'b0;
    logic                     i_sys_rst = 1'b1;
    logic                     i_clk_en = 1'b1;
    sles_pkg::sles_addr_t     i_addr = '0;
    sles_pkg::sles_byte_t     i_wr_data = '0;
    logic                     i_wr_stb = 1'b0;
    logic                     i_rd_stb = 1'b0;
    sles_pkg::sles_cnt_t      i_error_threshold = 8'hff;
    logic                     ld = 1'b0;
    sles_pkg::sles_err_kind_t kind = sles_pkg::SLES_ERR_DISP;
    sles_pkg::sles_cnt_t      val = '0;
    logic [2:0]               syn = '0;
    sles_pkg::sles_cnt_t      cnt [3];
    logic [2:0]               lvl;
    logic                     o_rd_valid;
    sles_pkg::sles_byte_t     o_rd_data;
    logic                     o_skip_initial_alignment;
    logic                     o_irq;
    sles_pkg::sles_cnt_t      m_cnt [3] = '{default: 8'h00};
    logic [2:0]               m_sync = '0;
    sles_pkg::sles_cnt_t      th = 8'hff;
    sles_pkg::sles_byte_t     exp_q [$];
    sles_pkg::sles_addr_t     idle_addr [6] = '{A6, A5, AS, AM, AC, 12'h123};
    int                       fail_count = 0;
    int                       check_count = 0;
    int                       cyc = 0;

    always #2 i_clk_sys = ~i_clk_sys;

    sles_lane_src sles_lane_src_i (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_load(ld),
        .i_kind(kind), .i_value(val), .i_sync(syn), .o_cnt(cnt), .o_sync(lvl));
    sles_lane_status sles_lane_status_i (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb),
        .i_rd_stb(i_rd_stb), .i_disp_err_cnt(cnt[0]), .i_invalid_err_cnt(cnt[1]),
        .i_ctrl_err_cnt(cnt[2]), .i_error_threshold(i_error_threshold),
        .i_lane6_deskew_ok(lvl[2]), .i_lane6_init_sync(lvl[1]), .i_lane5_group_sync(lvl[0]),
        .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
        .o_skip_initial_alignment(o_skip_initial_alignment), .o_irq(o_irq));

    function automatic sles_pkg::sles_byte_t e6();
        return {m_cnt[0] >= th, m_cnt[1] >= th, m_cnt[2] >= th, m_sync[2:1], 3'h0};
    endfunction

    task automatic cmp(input string what, input sles_pkg::sles_byte_t e,
                       input sles_pkg::sles_byte_t s);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask

    // a read notes its expected byte in d, n strobes back to back
    task automatic bus(input logic w, input sles_pkg::sles_addr_t a,
                       input sles_pkg::sles_byte_t d, input int n);
        @(posedge i_clk_sys);
        i_wr_stb  <= w;
        i_rd_stb  <= !w;
        i_addr    <= a;
        i_wr_data <= d;
        repeat (n) begin
            if (!w) exp_q.push_back(d);
            @(posedge i_clk_sys);
        end
        i_wr_stb <= 1'b0;
        i_rd_stb <= 1'b0;
    endtask

    task automatic src(input int k, input sles_pkg::sles_cnt_t v, input logic [2:0] s);
        @(posedge i_clk_sys);
        ld       <= 1'b1;
        kind     <= sles_pkg::sles_err_kind_t'(k);
        val      <= v;
        syn      <= s;
        m_cnt[k] = v;
        m_sync   = s;
        @(posedge i_clk_sys);
        ld <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
    endtask

    // interrupt lags the input change by three edges, so wait past it
    task automatic outs(input logic e_irq, input logic e_skip);
        repeat (4) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        cmp("irq", {7'h00, e_irq}, {7'h00, o_irq});
        cmp("skip", {7'h00, e_skip}, {7'h00, o_skip_initial_alignment});
    endtask

    always @(negedge i_clk_sys) begin
        if (o_rd_valid === 1'b1) cmp("rd_data", exp_q.pop_front(), o_rd_data);
    end

    task automatic final_report();
        // a read that never answered leaves its note behind
        if (exp_q.size() != 0) fail_count++;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // whole run needs well under a thousand cycles
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            final_report();
        end
    end

    initial begin
        void'($urandom(32'h69b9));
        repeat (8) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        foreach (idle_addr[i]) bus(1'b0, idle_addr[i], 8'h00, 1);
        for (int k = 0; k < 3; k++) begin
            th = sles_pkg::sles_cnt_t'(1 + $urandom % 254);
            @(posedge i_clk_sys);
            i_error_threshold <= th;
            for (int d = -1; d < 2; d++) begin
                src(k, sles_pkg::sles_cnt_t'(int'(th) + d), m_sync);
                bus(1'b0, A6, e6(), 1);
            end
            src(k, 8'h00, m_sync);
        end
        for (int s = 0; s < 8; s++) begin
            src(0, 8'h00, 3'(s));
            bus(1'b0, A6, e6(), 2);
            bus(1'b0, A5, {7'h00, m_sync[0]}, 1);
        end
        bus(1'b1, A6, 8'hff, 1);
        bus(1'b0, A6, e6(), 1);
        bus(1'b1, AS, 8'hff, 1);
        bus(1'b1, AM, 8'h80, 1);
        bus(1'b0, AM, 8'h80, 1);
        outs(1'b0, 1'b0);
        src(0, th, m_sync);
        outs(1'b1, 1'b0);
        bus(1'b0, AS, 8'h80, 1);
        bus(1'b1, AS, 8'h80, 1);
        outs(1'b0, 1'b0);
        bus(1'b1, AM, 8'h18, 1);
        bus(1'b1, AC, 8'h01, 1);
        src(0, th, 3'b001);
        outs(1'b0, 1'b1);
        bus(1'b0, A6, e6(), 1);
        bus(1'b1, AC, 8'h00, 1);
        src(0, th, 3'b111);
        src(0, th, 3'b001);
        outs(1'b1, 1'b0);
        // bit 7 stays clear: the disparity flag has not risen again since its clear
        bus(1'b0, AS, 8'h18, 1);
        // a write while the enable is low must not land
        @(posedge i_clk_sys);
        i_clk_en <= 1'b0;
        bus(1'b1, AM, 8'h01, 1);
        @(posedge i_clk_sys);
        i_clk_en <= 1'b1;
        bus(1'b0, AM, 8'h18, 1);
        repeat (4) @(posedge i_clk_sys);
        final_report();
    end
endmodule

bind sles_lane_status sles_lane_status_monitor sles_lane_status_monitor_i (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_rd_stb(i_rd_stb),
    .i_disp_err_cnt(i_disp_err_cnt), .i_invalid_err_cnt(i_invalid_err_cnt),
    .i_ctrl_err_cnt(i_ctrl_err_cnt), .i_error_threshold(i_error_threshold),
    .i_lane6_deskew_ok(i_lane6_deskew_ok), .i_lane6_init_sync(i_lane6_init_sync),
    .i_lane5_group_sync(i_lane5_group_sync), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data));
